// *** dwtc_pkg.sv ***
// Package: constants, register map and carriers of the write termination control block
package dwtc_pkg;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam int unsigned AXI_ADDR_W        = 8;
  localparam logic [7:0]  TERM_MODE_OFFSET  = 8'h00;
  localparam logic [7:0]  TIMING_CFG_OFFSET = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET     = 8'h08;
  localparam logic [7:0]  CA_TERM_OFFSET    = 8'h0C;

  localparam int unsigned DQ_MODE_MSB  = 3;
  localparam int unsigned RES_MSB      = 2;
  localparam int unsigned CA_RES_LSB   = 4;
  localparam int unsigned CA_RES_MSB   = 6;
  localparam int unsigned BIN_MSB      = 2;
  localparam int unsigned WRITE_LATENCY_SET_BIT   = 4;
  localparam int unsigned BL32_BIT     = 8;
  localparam int unsigned ST_DQ_BIT    = 0;
  localparam int unsigned ST_DQS_BIT   = 1;
  localparam int unsigned ST_VALID_BIT = 2;
  localparam int unsigned ST_ARMED_BIT = 3;
  localparam int unsigned ST_ON_LSB    = 8;
  localparam int unsigned ST_OFF_LSB   = 16;
  localparam int unsigned ST_OHM_LSB   = 24;
  localparam int unsigned CA_PEND_BIT  = 4;

  localparam logic [6:0]  TERM_MODE_RESET  = 7'h00;
  localparam logic [8:0]  TIMING_CFG_RESET = 9'h000;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CORE_PERIOD_PS     = 4000;
  localparam int unsigned TERM_SETTLE_MIN_PS = 1500;
  localparam int unsigned TERM_SETTLE_MAX_PS = 3500;
  localparam int unsigned SETTLE_MAX_FLOOR   = TERM_SETTLE_MAX_PS / CORE_PERIOD_PS;
  localparam int unsigned TERM_SETTLE_CYCLES = (SETTLE_MAX_FLOOR < 1) ? 1 : SETTLE_MAX_FLOOR;
  localparam logic [5:0]  BL32_EXTRA_CYCLES  = 6'h08;

  // Latency per frequency bin; zero marks a bin without a defined entry
  localparam logic [5:0] ON_LAT_A  [8] = '{6'h00, 6'h00, 6'h00, 6'h04, 6'h04, 6'h06, 6'h06, 6'h08};
  localparam logic [5:0] OFF_LAT_A [8] = '{6'h00, 6'h00, 6'h00, 6'h14, 6'h16, 6'h18, 6'h1A, 6'h1C};
  localparam logic [5:0] ON_LAT_B  [8] = '{6'h00, 6'h00, 6'h06, 6'h0C, 6'h0E, 6'h12, 6'h14, 6'h18};
  localparam logic [5:0] OFF_LAT_B [8] = '{6'h00, 6'h00, 6'h16, 6'h1C, 6'h20, 6'h24, 6'h28, 6'h2C};

  localparam logic [7:0] CAL_RES_OHMS = 8'hF0;
  localparam logic [7:0] RES_OHMS [8] = '{8'h00, CAL_RES_OHMS, 8'h78, 8'h50,
                                          8'h3C, 8'h30, 8'h28, 8'h00};

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic link_ck;
    logic write_first;
    logic masked_write_first;
    logic col_second;
    logic power_down;
    logic self_refresh;
    logic write_leveling;
  } dwtc_pin_type;

  typedef struct packed {
    logic dq;
    logic data_mask_inversion;
    logic dqs;
  } dwtc_term_type;

endpackage : dwtc_pkg

// *** dwtc_top.sv ***
// Write termination control: latency sequencer, pin enables and AXI4-Lite registers
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module dwtc_top #(
  parameter int unsigned CA_TERM_UPDATE_NS = 20
) (
  input  wire logic                                 CORE_CLK,
  input  wire logic                                 RST_N,
  input  wire logic [dwtc_pkg::AXI_ADDR_W-1:0]      S_AXI_AWADDR,
  input  wire logic                                 S_AXI_AWVALID,
  output logic                                      S_AXI_AWREADY,
  input  wire logic [31:0]                          S_AXI_WDATA,
  input  wire logic [3:0]                           S_AXI_WSTRB,
  input  wire logic                                 S_AXI_WVALID,
  output logic                                      S_AXI_WREADY,
  output logic [1:0]                                S_AXI_BRESP,
  output logic                                      S_AXI_BVALID,
  input  wire logic                                 S_AXI_BREADY,
  input  wire logic [dwtc_pkg::AXI_ADDR_W-1:0]      S_AXI_ARADDR,
  input  wire logic                                 S_AXI_ARVALID,
  output logic                                      S_AXI_ARREADY,
  output logic [31:0]                               S_AXI_RDATA,
  output logic [1:0]                                S_AXI_RRESP,
  output logic                                      S_AXI_RVALID,
  input  wire logic                                 S_AXI_RREADY,
  input  wire dwtc_pkg::dwtc_pin_type               LINK_PINS,
  output dwtc_pkg::dwtc_term_type                   TERM_OUT,
  output logic [2:0]                                TERM_RES_CODE,
  output logic [2:0]                                CA_TERM_CODE
);
  import dwtc_pkg::*;

  // ----------------------------------------------------------------------
  // Derived timing
  // ----------------------------------------------------------------------
  localparam int unsigned CA_UPD_RAW = (CA_TERM_UPDATE_NS * 1000 + CORE_PERIOD_PS - 1)
                                       / CORE_PERIOD_PS;
  localparam logic [15:0] CA_UPD_CYCLES = 16'((CA_UPD_RAW < 1) ? 1 : CA_UPD_RAW);

  // ----------------------------------------------------------------------
  // Pin synchronisers and link clock edge
  // ----------------------------------------------------------------------
  dwtc_pin_type pins_meta;
  dwtc_pin_type pins;
  logic         ck_prev;
  logic         ck_rise;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pins_meta <= '0;
      pins      <= '0;
      ck_prev   <= 1'b0;
    end else begin
      pins_meta <= LINK_PINS;
      pins      <= pins_meta;
      ck_prev   <= pins.link_ck;
    end
  end

  // Commands share the clock's synchroniser, so both are seen at the same edge
  assign ck_rise = pins.link_ck & ~ck_prev;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [6:0]  term_mode;
  logic [8:0]  timing_cfg;
  logic        dq_mode;
  logic [2:0]  bin;
  logic [5:0]  lat_on_sel;
  logic [5:0]  lat_off_sel;
  logic        table_ok;
  logic [5:0]  next_off_base;
  // Bins without a table entry read back a zero on-latency and never start a sequence

  assign dq_mode    = |term_mode[DQ_MODE_MSB:0];
  assign bin        = timing_cfg[BIN_MSB:0];
  assign lat_on_sel = timing_cfg[WRITE_LATENCY_SET_BIT] ? ON_LAT_B[bin] : ON_LAT_A[bin];
  assign table_ok   = (lat_on_sel != 6'h00);

  always_comb begin
    next_off_base = timing_cfg[WRITE_LATENCY_SET_BIT] ? OFF_LAT_B[bin] : OFF_LAT_A[bin];
    lat_off_sel   = next_off_base;
    if (timing_cfg[BL32_BIT]) begin
      lat_off_sel = 6'(next_off_base + BL32_EXTRA_CYCLES);
    end
  end

  // ----------------------------------------------------------------------
  // Write sequencer
  // ----------------------------------------------------------------------
  // Latencies are captured at the column command so a register write during
  // a burst cannot move the pending edges.
  logic       blocked;
  logic       armed;
  logic       seq_active;
  logic [5:0] lat_cnt;
  logic [5:0] lat_on_q;
  logic [5:0] lat_off_q;
  logic [5:0] next_cnt;
  logic       on_hit;
  logic       off_hit;
  logic       dq_on;
  logic       wr_cmd;

  assign blocked  = pins.power_down | pins.self_refresh | ~dq_mode
                    | pins.write_leveling;
  assign wr_cmd   = pins.write_first | pins.masked_write_first;
  assign next_cnt = 6'(lat_cnt + 6'h01);
  assign on_hit   = ck_rise & seq_active & (next_cnt == lat_on_q);
  assign off_hit  = ck_rise & seq_active & (next_cnt == lat_off_q);

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      armed      <= 1'b0;
      seq_active <= 1'b0;
      lat_cnt    <= 6'h00;
      lat_on_q   <= 6'h00;
      lat_off_q  <= 6'h00;
    end else if (blocked) begin
      armed      <= 1'b0;
      seq_active <= 1'b0;
    end else if (ck_rise) begin
      if (wr_cmd) begin
        armed <= 1'b1;
      end else if (pins.col_second) begin
        armed <= 1'b0;
      end
      if (pins.col_second & armed & table_ok) begin
        seq_active <= 1'b1;
        lat_cnt    <= 6'h00;
        lat_on_q   <= lat_on_sel;
        lat_off_q  <= lat_off_sel;
      end else if (seq_active) begin
        lat_cnt <= next_cnt;
        if (off_hit) begin
          seq_active <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Termination switch
  // ----------------------------------------------------------------------
  // The switch moves two core cycles after the latency edge, later than the
  // settle window; the link-edge sampling itself adds two cycles of skew.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dq_on <= 1'b0;
    end else if (blocked | off_hit) begin
      dq_on <= 1'b0;
    end else if (on_hit) begin
      dq_on <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TERM_OUT <= '0;
    end else begin
      TERM_OUT.dq  <= dq_on & ~pins.write_leveling;
      TERM_OUT.data_mask_inversion <= dq_on & ~pins.write_leveling;
      // In leveling the strobe follows the mode field unless in power-down or self-refresh; data pins stay off
      if (pins.write_leveling) begin
        TERM_OUT.dqs <= dq_mode & ~pins.power_down & ~pins.self_refresh;
      end else begin
        TERM_OUT.dqs <= dq_on;
      end
    end
  end

  assign TERM_RES_CODE = term_mode[RES_MSB:0];

  // ----------------------------------------------------------------------
  // Command-bus termination update
  // ----------------------------------------------------------------------
  // The pins keep the old code until the update time runs out; a second
  // mode write restarts the wait.
  logic        mode_wr;
  logic        ca_pending;
  logic [15:0] ca_cnt;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CA_TERM_CODE <= TERM_MODE_RESET[CA_RES_MSB:CA_RES_LSB];
      ca_pending   <= 1'b0;
      ca_cnt       <= 16'h0000;
    end else if (mode_wr) begin
      ca_pending <= 1'b1;
      ca_cnt     <= CA_UPD_CYCLES;
    end else if (ca_pending) begin
      ca_cnt <= ca_cnt - 16'h0001;
      if (ca_cnt == 16'h0001) begin
        ca_pending   <= 1'b0;
        CA_TERM_CODE <= term_mode[CA_RES_MSB:CA_RES_LSB];
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic                  aw_held;
  logic                  w_held;
  logic [AXI_ADDR_W-1:0] aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  do_write;
  logic [31:0]           wmask;
  logic [31:0]           rd_word;
  logic                  rd_hit;

  // Ready stays low while a response waits, so one write and one read at
  // most are ever in flight.
  assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = ~w_held & ~S_AXI_BVALID;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  assign do_write      = aw_held & w_held;
  assign mode_wr       = do_write & (aw_addr == TERM_MODE_OFFSET) & w_strb[0];

  for (genvar b = 0; b < 4; b++) begin : g_mask
    assign wmask[8*b+7:8*b] = {8{w_strb[b]}};
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      term_mode  <= TERM_MODE_RESET;
      timing_cfg <= TIMING_CFG_RESET;
    end else if (do_write) begin
      if (aw_addr == TERM_MODE_OFFSET) begin
        term_mode <= (term_mode & ~wmask[6:0]) | (w_data[6:0] & wmask[6:0]);
      end
      if (aw_addr == TIMING_CFG_OFFSET) begin
        timing_cfg <= (timing_cfg & ~wmask[8:0]) | (w_data[8:0] & wmask[8:0]);
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      if ((aw_addr == TERM_MODE_OFFSET) | (aw_addr == TIMING_CFG_OFFSET)) begin
        S_AXI_BRESP <= RESP_OKAY;
      end else begin
        S_AXI_BRESP <= RESP_SLVERR;
      end
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (S_AXI_ARADDR)
      TERM_MODE_OFFSET:  rd_word[6:0] = term_mode;
      TIMING_CFG_OFFSET: rd_word[8:0] = timing_cfg;
      STATUS_OFFSET: begin
        rd_word[ST_DQ_BIT]                 = TERM_OUT.dq;
        rd_word[ST_DQS_BIT]                = TERM_OUT.dqs;
        rd_word[ST_VALID_BIT]              = table_ok;
        rd_word[ST_ARMED_BIT]              = armed;
        rd_word[ST_ON_LSB+5:ST_ON_LSB]     = lat_on_sel;
        rd_word[ST_OFF_LSB+5:ST_OFF_LSB]   = lat_off_sel;
        rd_word[ST_OHM_LSB+7:ST_OHM_LSB]   = RES_OHMS[term_mode[RES_MSB:0]];
      end
      CA_TERM_OFFSET: begin
        rd_word[2:0]         = CA_TERM_CODE;
        rd_word[CA_PEND_BIT] = ca_pending;
      end
      default:           rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= RESP_OKAY;
    end else if (S_AXI_ARVALID & S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_word;
      S_AXI_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule : dwtc_top

`default_nettype wire

// *** dwtc_top_sva.sv ***
// Checker: termination pin rules and register-side timing of the write termination block
`timescale 1ns/1ps
`default_nettype none

module dwtc_top_sva #(
  parameter int unsigned CA_TERM_UPDATE_NS = 20
) (
  input wire logic                    CORE_CLK,
  input wire logic                    RST_N,
  input wire logic                    S_AXI_BVALID,
  input wire dwtc_pkg::dwtc_pin_type  LINK_PINS,
  input wire dwtc_pkg::dwtc_term_type TERM_OUT,
  input wire logic [2:0]              TERM_RES_CODE,
  input wire logic [2:0]              CA_TERM_CODE
);
  import dwtc_pkg::*;
  localparam int unsigned UPD = (CA_TERM_UPDATE_NS + 3) / 4;
  logic [7:0] since_wr;

  // Saturates so a long idle stretch never wraps back into the wait window
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) since_wr <= 8'hFF;
    else if ($rose(S_AXI_BVALID)) since_wr <= 8'h00;
    else if (since_wr != 8'hFF) since_wr <= since_wr + 8'h01;
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  chk_lowpow_off: assert property (
    (LINK_PINS.power_down || LINK_PINS.self_refresh)[*5] |-> TERM_OUT == 3'b000)
    else $error("termination on in low power state");
  chk_level_dq_off: assert property (
    LINK_PINS.write_leveling[*5] |-> !TERM_OUT.dq && !TERM_OUT.data_mask_inversion)
    else $error("data termination on during leveling");
  chk_level_dqs_on: assert property (
    (LINK_PINS.write_leveling && TERM_RES_CODE != 3'h0
     && !LINK_PINS.power_down && !LINK_PINS.self_refresh)[*5] |-> TERM_OUT.dqs)
    else $error("strobe termination off during leveling");
  chk_mask_follows: assert property (
    TERM_OUT.data_mask_inversion == TERM_OUT.dq) else $error("mask pin differs from data pins");
  chk_strobe_follows: assert property (
    (!LINK_PINS.write_leveling)[*5] |-> TERM_OUT.dqs == TERM_OUT.dq)
    else $error("strobe pins differ from data pins");
  chk_res_by_write: assert property (
    $changed(TERM_RES_CODE) |-> $rose(S_AXI_BVALID))
    else $error("resistance code moved without a write");
  chk_ca_reset_off: assert property (
    $rose(RST_N) |-> CA_TERM_CODE == 3'h0) else $error("command termination on after reset");
  chk_ca_update_wait: assert property (
    $changed(CA_TERM_CODE) |-> since_wr >= 8'(UPD - 1))
    else $error("command termination applied before update time");
endmodule : dwtc_top_sva

bind dwtc_top dwtc_top_sva #(.CA_TERM_UPDATE_NS(CA_TERM_UPDATE_NS)) u_sva (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .S_AXI_BVALID(S_AXI_BVALID),
  .LINK_PINS(LINK_PINS), .TERM_OUT(TERM_OUT), .TERM_RES_CODE(TERM_RES_CODE),
  .CA_TERM_CODE(CA_TERM_CODE)
);
`default_nettype wire

// *** dwtc_ctrl_model.sv ***
// Memory controller model: link clock, column commands and power states
`timescale 1ns/1ps
`default_nettype none

module dwtc_ctrl_model (
  output wire dwtc_pkg::dwtc_pin_type pins
);
  import dwtc_pkg::*;
  logic       ck    = 1'b0;
  logic [2:0] cmd   = 3'h0;
  logic [2:0] state = 3'h0;

  // Runs free as a memory clock does; the offset keeps it off the core clock edges
  initial begin
    #13.3;
    forever #32 ck = ~ck;
  end
  assign pins = {ck, cmd, state};

  // Command held across exactly one rising link edge, then back to no command
  task automatic issue(input logic [2:0] c);
    @(negedge ck);
    cmd = c;
    @(negedge ck);
    cmd = 3'h0;
  endtask : issue

  task automatic set_state(input logic [2:0] s);
    @(negedge ck);
    state = s;
  endtask : set_state
endmodule : dwtc_ctrl_model
`default_nettype wire

// *** dwtc_top_bench.sv ***
// Self-checking bench for the write termination control block
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
  end \
end

module dwtc_top_bench;
  import dwtc_pkg::*;
  logic          clk = 1'b0, rst_n = 1'b0;
  logic [7:0]    addr = 8'h00;
  logic [31:0]   wdata = 32'h0, rdata, q;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic          awready, wready, bvalid, arready, rvalid, setb, bl;
  logic [1:0]    bresp, rresp, r;
  logic [2:0]    res_code, ca_code, bin;
  logic [3:0]    wstrb = 4'hF;
  dwtc_term_type term;
  dwtc_pin_type  link_pins;
  int            num_errors = 0, compares = 0, cycles = 0, on, off;
  int on_a [8] = '{0, 0, 0, 4, 4, 6, 6, 8};
  int off_a [8] = '{0, 0, 0, 20, 22, 24, 26, 28};
  int on_b [8] = '{0, 0, 6, 12, 14, 18, 20, 24};
  int off_b [8] = '{0, 0, 22, 28, 32, 36, 40, 44};
  logic [6:0] c_mode [5] = '{7'h09, 7'h01, 7'h09, 7'h00, 7'h09};
  logic [8:0] c_cfg [5] = '{9'h003, 9'h112, 9'h003, 9'h003, 9'h001};
  logic [2:0] c_arm [5] = '{3'b100, 3'b010, 3'b000, 3'b100, 3'b100};
  int c_on [5] = '{4, 6, 0, 0, 0};
  int c_off [5] = '{20, 30, 0, 0, 0};

  always #2 clk = ~clk;

  dwtc_ctrl_model ctrl (.pins(link_pins));
  dwtc_top #(.CA_TERM_UPDATE_NS(16)) dut (
    .CORE_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(addr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(addr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .LINK_PINS(link_pins), .TERM_OUT(term), .TERM_RES_CODE(res_code), .CA_TERM_CODE(ca_code)
  );

  // Ready is looked at mid-cycle, where it has settled, and acted on at the next edge
  task automatic access(input bit wr, input logic [7:0] a, input logic [31:0] d);
    bit aw, w, ar, done;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    done = 1'b0;
    while (!done) begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      ar = arvalid && arready;
      done = wr ? bvalid : rvalid;
      q = rdata;
      r = wr ? bresp : rresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (ar) arvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
  endtask : access

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // Whole run needs well under 10000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    access(1'b0, TERM_MODE_OFFSET, 32'h0);
    `CHECK(q, 32'h0)
    access(1'b0, CA_TERM_OFFSET, 32'h0);
    `CHECK(q, 32'h0)
    `CHECK(term, 3'b000)
    $display("reset test done");
    for (int i = 0; i < 32; i++) begin
      {bl, setb, bin} = 5'(i);
      on = setb ? on_b[bin] : on_a[bin];
      off = (setb ? off_b[bin] : off_a[bin]) + 8 * bl;
      access(1'b1, TIMING_CFG_OFFSET, {23'h0, bl, 3'h0, setb, 1'b0, bin});
      access(1'b0, STATUS_OFFSET, 32'h0);
      `CHECK(q[2], on != 0)
      if (on != 0) `CHECK({q[13:8], q[21:16]}, {6'(on), 6'(off)})
    end
    $display("latency table test done");
    for (int c = 0; c < 8; c++) begin
      access(1'b1, TERM_MODE_OFFSET, 32'h8 | 32'(c));
      access(1'b0, STATUS_OFFSET, 32'h0);
      `CHECK(q[31:24], (c > 0 && c < 7) ? 8'(32'hF0 / c) : 8'h00)
      `CHECK(res_code, 3'(c))
    end
    $display("resistance test done");
    for (int i = 0; i < 5; i++) begin
      access(1'b1, TERM_MODE_OFFSET, {25'h0, c_mode[i]});
      access(1'b1, TIMING_CFG_OFFSET, {23'h0, c_cfg[i]});
      if (c_arm[i] != 3'h0) ctrl.issue(c_arm[i]);
      ctrl.issue(3'b001);
      for (int k = 1; k < 34; k++) begin
        @(posedge link_pins.link_ck);
        repeat (6) @(posedge clk);
        `CHECK(term, (k >= c_on[i] && k < c_off[i]) ? 3'b111 : 3'b000)
      end
    end
    $display("write sequence test done");
    access(1'b1, TIMING_CFG_OFFSET, 32'h3);
    for (int s = 0; s < 2; s++) begin
      ctrl.issue(3'b100);
      ctrl.issue(3'b001);
      repeat (6) @(posedge link_pins.link_ck);
      `CHECK(term, 3'b111)
      access(1'b0, STATUS_OFFSET, 32'h0);
      `CHECK(q[3:0], 4'b0111)
      ctrl.set_state(s ? 3'b010 : 3'b100);
      repeat (8) @(posedge clk);
      `CHECK(term, 3'b000)
      ctrl.set_state(3'h0);
    end
    ctrl.set_state(3'b001);
    repeat (8) @(posedge clk);
    `CHECK(term, 3'b001)
    access(1'b1, TERM_MODE_OFFSET, 32'h0);
    repeat (4) @(posedge clk);
    `CHECK(term, 3'b000)
    ctrl.set_state(3'h0);
    $display("power and leveling test done");
    access(1'b1, TERM_MODE_OFFSET, 32'h35);
    // 16 ns at 4 ns a cycle: the code moves four edges after the register write
    repeat (3) @(negedge clk);
    `CHECK(ca_code, 3'h0)
    @(negedge clk);
    `CHECK(ca_code, 3'h3)
    @(posedge clk);
    wstrb <= 4'hE;
    access(1'b1, TERM_MODE_OFFSET, 32'h0);
    `CHECK(r, RESP_OKAY)
    wstrb <= 4'hF;
    access(1'b0, TERM_MODE_OFFSET, 32'h0);
    `CHECK(q, 32'h35)
    access(1'b0, CA_TERM_OFFSET, 32'h0);
    `CHECK(q, 32'h3)
    access(1'b1, STATUS_OFFSET, 32'h0);
    `CHECK(r, RESP_SLVERR)
    access(1'b0, 8'h10, 32'h0);
    `CHECK(r, RESP_SLVERR)
    $display("command termination test done");
    finish_test();
  end
endmodule : dwtc_top_bench
`default_nettype wire
